// ### rtl/pin_function_mux_sync.sv
// General pin function mux, input routing and ramp phase sync control
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module pin_function_mux_sync
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        warning_out_n,
	input  wire logic        fault_out_n,
	input  wire logic        serial_audio_data_out,
	input  wire logic        supply_drop_flag,
	input  wire logic        class_h_control,
	input  wire logic        internal_sync,
	input  wire logic [2:0]  pin_in,
	output logic      [2:0]  pin_out,
	output logic      [2:0]  pin_oe,
	output logic             drivers_hiz,
	output logic             switching_stop,
	output logic             pin_reset_req,
	output logic             spi_data_in,
	output logic             ramp_sync_pulse,
	output logic      [1:0]  ramp_phase_sel,
	output logic      [7:0]  ramp_phase_deg
);

	typedef struct packed {
		logic [2:0]  direction;
		logic [3:0]  fsel0;
		logic [7:0]  route;
		logic [2:0]  level;
		logic [2:0]  invert;
		logic [3:0]  phase;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
		logic [2:0]  pin_out;
		logic [2:0]  pin_oe;
		logic        halt;
		logic        reset_req;
		logic        spi_data;
		logic        sync_prev;
		logic        sync_pulse;
		logic [7:0]  phase_deg;
	} state_s;

	state_s      r_reg;
	state_s      r_next;
	pin_route_if rt ();

	pin_input_sync u_sync
	(
		.mclk   (mclk),
		.reset  (reset),
		.pin_in (pin_in),
		.bus    (rt)
	);

	// ----------------------------------------------------------------
	// Decode and pin 0 source
	// ----------------------------------------------------------------
	logic [9:0] index;
	logic       mapped;
	logic       access;
	logic       commit;
	logic [7:0] read_val;
	logic       src0;
	logic [2:0] drive;
	logic       sync_src;
	logic [1:0] mute_rt;
	logic [1:0] reset_rt;

	assign index    = paddr[pin_mux_pkg::ADDR_W-1:2];
	assign access   = psel && penable && !r_reg.ready;
	// Writes land only on the edge where the master sees pready high
	assign commit   = psel && penable && r_reg.ready && pwrite && mapped;
	assign mute_rt  = r_reg.route[pin_mux_pkg::RT_MUTE_LSB +: 2];
	assign reset_rt = r_reg.route[pin_mux_pkg::RT_RESET_LSB +: 2];

	always_comb
	begin
		mapped   = paddr[1:0] == pin_mux_pkg::WORD_ALIGNED;
		read_val = pin_mux_pkg::REG_RESET;
		case (index)
			pin_mux_pkg::IDX_DIRECTION: read_val = {5'h00, r_reg.direction};
			pin_mux_pkg::IDX_FSEL0:     read_val = {4'h0, r_reg.fsel0};
			pin_mux_pkg::IDX_ROUTE:     read_val = r_reg.route;
			pin_mux_pkg::IDX_LEVEL:     read_val = {5'h00, r_reg.level};
			pin_mux_pkg::IDX_INVERT:    read_val = {5'h00, r_reg.invert};
			pin_mux_pkg::IDX_PHASE:     read_val = {4'h0, r_reg.phase};
			default:                    mapped   = 1'b0;
		endcase
	end

	always_comb
	begin
		src0 = 1'b0;
		case (r_reg.fsel0)
			pin_mux_pkg::FS_LOW:    src0 = 1'b0;
			pin_mux_pkg::FS_WARN:   src0 = warning_out_n;
			pin_mux_pkg::FS_FAULT:  src0 = fault_out_n;
			pin_mux_pkg::FS_SERIAL_AUDIO_DATA_OUT:  src0 = serial_audio_data_out;
			pin_mux_pkg::FS_DROP:   src0 = supply_drop_flag;
			pin_mux_pkg::FS_CLASSH: src0 = class_h_control;
			default:                src0 = 1'b0;
		endcase
		// Pin 0 has no software-driven code, so its level bit only stores
		drive    = pin_mux_pkg::field_to_pins(r_reg.level);
		drive[0] = src0;
		sync_src = r_reg.phase[pin_mux_pkg::PH_SRC_BIT] ? internal_sync
			: pin_mux_pkg::route_pick(r_reg.route[pin_mux_pkg::RT_SYNC_LSB +: 2],
				rt.pin_level, 1'b0);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		r_next        = r_reg;
		r_next.ready  = access;
		r_next.slverr = access && !mapped;
		r_next.rdata  = (access && !pwrite && mapped) ? {24'h000000, read_val} : 32'h00000000;
		if (commit)
		begin
			case (index)
				pin_mux_pkg::IDX_DIRECTION: r_next.direction = pwdata[2:0];
				pin_mux_pkg::IDX_FSEL0:     r_next.fsel0     = pwdata[3:0];
				pin_mux_pkg::IDX_ROUTE:     r_next.route     = pwdata[7:0];
				pin_mux_pkg::IDX_LEVEL:     r_next.level     = pwdata[2:0];
				pin_mux_pkg::IDX_INVERT:    r_next.invert    = pwdata[2:0];
				// Changing phase while playing is not guarded here
				pin_mux_pkg::IDX_PHASE:     r_next.phase     = pwdata[3:0];
				default:                    r_next.phase     = r_reg.phase;
			endcase
		end
		r_next.pin_out   = drive ^ pin_mux_pkg::field_to_pins(r_reg.invert);
		r_next.pin_oe    = pin_mux_pkg::field_to_pins(r_reg.direction);
		// Idle value of 1 keeps unrouted active-low inputs inactive
		r_next.halt      = !pin_mux_pkg::route_pick(mute_rt, rt.pin_level, 1'b1);
		r_next.reset_req = (reset_rt != pin_mux_pkg::RT_PIN0)
			&& !pin_mux_pkg::route_pick(reset_rt, rt.pin_level, 1'b1);
		r_next.spi_data  = pin_mux_pkg::route_pick(r_reg.route[pin_mux_pkg::RT_SPI_LSB +: 2],
			rt.pin_level, 1'b0);
		r_next.sync_prev  = sync_src;
		r_next.sync_pulse = r_reg.phase[pin_mux_pkg::PH_EN_BIT]
			&& sync_src && !r_reg.sync_prev;
		r_next.phase_deg  = 8'({6'h00, r_reg.phase[pin_mux_pkg::PH_SEL_LSB +: 2]}
			* pin_mux_pkg::PH_STEP_DEG);
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata          = r_reg.rdata;
	assign pready          = r_reg.ready;
	assign pslverr         = r_reg.slverr;
	assign pin_out         = r_reg.pin_out;
	assign pin_oe          = r_reg.pin_oe;
	assign drivers_hiz     = r_reg.halt;
	assign switching_stop  = r_reg.halt;
	assign pin_reset_req   = r_reg.reset_req;
	assign spi_data_in     = r_reg.spi_data;
	assign ramp_sync_pulse = r_reg.sync_pulse;
	assign ramp_phase_sel  = r_reg.phase[pin_mux_pkg::PH_SEL_LSB +: 2];
	assign ramp_phase_deg  = r_reg.phase_deg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence apb_access_s;
		psel && penable && !pready;
	endsequence

	sequence apb_done_s;
		pready && psel && penable;
	endsequence

	sequence sync_edge_s;
		(!r_reg.sync_prev && r_reg.phase[pin_mux_pkg::PH_EN_BIT]) ##1 r_reg.sync_prev;
	endsequence

	apb_answer_a: assert property (apb_access_s |=> apb_done_s)
		else $error("apb access not answered in one cycle");
	warn_route_a: assert property (r_reg.fsel0 == pin_mux_pkg::FS_WARN
		|=> pin_out[0] == ($past(warning_out_n) ^ $past(r_reg.invert[2])))
		else $error("pin 0 does not carry warning");
	serial_audio_data_out_route_a: assert property (r_reg.fsel0 == pin_mux_pkg::FS_SERIAL_AUDIO_DATA_OUT
		|=> pin_out[0] == ($past(serial_audio_data_out) ^ $past(r_reg.invert[2])))
		else $error("pin 0 does not carry audio data");
	drop_route_a: assert property (r_reg.fsel0 == pin_mux_pkg::FS_DROP
		|=> pin_out[0] == ($past(supply_drop_flag) ^ $past(r_reg.invert[2])))
		else $error("pin 0 does not carry drop flag");
	undef_low_a: assert property (r_reg.fsel0[3] == 1'b0
		|=> pin_out[0] == $past(r_reg.invert[2]))
		else $error("pin 0 not low for off code");
	pin0_reset_a: assert property (reset_rt == pin_mux_pkg::RT_PIN0 |=> !pin_reset_req)
		else $error("pin 0 caused a reset");
	mute_halt_a: assert property (mute_rt == pin_mux_pkg::RT_PIN2 && !rt.pin_level[2]
		|=> drivers_hiz && switching_stop)
		else $error("mute did not halt output");
	spi_none_a: assert property (r_reg.route[7:6] == pin_mux_pkg::RT_NONE |=> !spi_data_in)
		else $error("spi input routed with no pin");
	sw_level_a: assert property (1'b1
		|=> pin_out[1] == ($past(r_reg.level[0]) ^ $past(r_reg.invert[0])))
		else $error("pin 1 level wrong");
	invert_a: assert property ($rose(r_reg.invert[1]) && $stable(r_reg.level[1])
		|=> $changed(pin_out[2]))
		else $error("pin 2 invert had no effect");
	phase_deg_a: assert property (ramp_phase_sel == 2'h3 ##1 ramp_phase_sel == 2'h3
		|-> ramp_phase_deg == 8'h87)
		else $error("phase step not 45 degrees");
	sync_off_a: assert property (!r_reg.phase[pin_mux_pkg::PH_EN_BIT] |=> !ramp_sync_pulse)
		else $error("sync while disabled");
	sync_pulse_a: assert property (sync_edge_s |-> ramp_sync_pulse)
		else $error("sync edge missed");
	direction_a: assert property (1'b1 |=> pin_oe[0] == $past(r_reg.direction[2]))
		else $error("pin 0 direction wrong");

endmodule

// ### rtl/pin_mux_pkg.sv
// Constants, field layout and helpers of the general pin function logic
package pin_mux_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0]  IDX_DIRECTION = 10'h060;
	localparam logic [9:0]  IDX_FSEL0     = 10'h063;
	localparam logic [9:0]  IDX_ROUTE     = 10'h064;
	localparam logic [9:0]  IDX_LEVEL     = 10'h065;
	localparam logic [9:0]  IDX_INVERT    = 10'h066;
	localparam logic [9:0]  IDX_PHASE     = 10'h06a;
	localparam int          ADDR_W        = 12;
	localparam logic [1:0]  WORD_ALIGNED  = 2'h0;
	localparam logic [7:0]  REG_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// Function select codes of general pin 0
	// ----------------------------------------------------------------
	localparam logic [3:0]  FS_LOW        = 4'h0;
	localparam logic [3:0]  FS_WARN       = 4'h8;
	localparam logic [3:0]  FS_SERIAL_AUDIO_DATA_OUT      = 4'h9;
	localparam logic [3:0]  FS_FAULT      = 4'hb;
	localparam logic [3:0]  FS_DROP       = 4'hc;
	localparam logic [3:0]  FS_CLASSH     = 4'hd;

	// ----------------------------------------------------------------
	// Input routing codes and field positions
	// ----------------------------------------------------------------
	localparam logic [1:0]  RT_NONE       = 2'h0;
	localparam logic [1:0]  RT_PIN1       = 2'h1;
	localparam logic [1:0]  RT_PIN2       = 2'h2;
	localparam logic [1:0]  RT_PIN0       = 2'h3;
	localparam int          RT_MUTE_LSB   = 0;
	localparam int          RT_RESET_LSB  = 2;
	localparam int          RT_SYNC_LSB   = 4;
	localparam int          RT_SPI_LSB    = 6;

	// ----------------------------------------------------------------
	// Ramp phase control fields
	// ----------------------------------------------------------------
	localparam int          PH_EN_BIT     = 0;
	localparam int          PH_SRC_BIT    = 1;
	localparam int          PH_SEL_LSB    = 2;
	localparam logic [7:0]  PH_STEP_DEG   = 8'h2d;
	localparam logic [2:0]  PIN_IDLE      = 3'h7;

	// Register fields hold pin 1 in bit 0, pin 2 in bit 1, pin 0 in bit 2
	function automatic logic [2:0] field_to_pins(logic [2:0] f);
		return {f[1], f[0], f[2]};
	endfunction

	function automatic logic route_pick(logic [1:0] code, logic [2:0] pins, logic idle);
		logic v;
		v = idle;
		unique case (code)
			RT_NONE: v = idle;
			RT_PIN1: v = pins[1];
			RT_PIN2: v = pins[2];
			RT_PIN0: v = pins[0];
		endcase
		return v;
	endfunction

endpackage

// ### rtl/pin_route_if.sv
// Synchronised pin levels passed from the input stage to the pin logic
`timescale 1ns/100ps
interface pin_route_if;
	logic [2:0] pin_level;
	modport src (output pin_level);
	modport dst (input  pin_level);
endinterface

// ### rtl/pin_input_sync.sv
// Two-flop synchronisers for the three general pin inputs
`timescale 1ns/100ps
module pin_input_sync
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [2:0] pin_in,
	pin_route_if.src        bus
);

	typedef struct packed {
		logic [2:0] stage1;
		logic [2:0] stage2;
	} sync_s;

	sync_s sync_reg;
	sync_s sync_next;

	// Pins reset to the idle high level so no mute or reset fires early
	always_comb
	begin
		sync_next = sync_reg;
		for (int i = 0; i < 3; i++)
		begin
			sync_next.stage1[i] = pin_in[i];
			sync_next.stage2[i] = sync_reg.stage1[i];
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			sync_reg <= {pin_mux_pkg::PIN_IDLE, pin_mux_pkg::PIN_IDLE};
		else
			sync_reg <= sync_next;
	end

	assign bus.pin_level = sync_reg.stage2;

endmodule

// ### verif/pin_far_side.sv
// Far-side model of the three general pins: pull-ups and external drivers
`timescale 1ns/100ps
module pin_far_side
(
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe,
	input  wire logic [2:0] ext_en,
	input  wire logic [2:0] ext_val,
	output logic      [2:0] pin_in
);
	// Released pins with no external driver go to the pull-up level, never to the last driven value
	// Peer amplifiers share ramp rate and spread settings, none driven here
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
	end
endmodule

// ### verif/pin_function_mux_sync_tb.sv
// Self-checking bench of the general pin function logic
`timescale 1ns/100ps
module pin_function_mux_sync_tb;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	typedef struct packed {logic [3:0] fs; logic [2:0] inv, lvl; logic [4:0] src;
		logic [2:0] pins;} row_s;
	logic        mclk, reset, psel, penable, pwrite, pready, pslverr, isync, err;
	logic        hiz, stop, rreq, spi, spulse;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  src;
	logic [2:0]  pin_in, pin_out, pin_oe, ext_en, ext_val;
	logic [1:0]  ph_sel;
	logic [7:0]  ph_deg;
	int          miscompares, n_tests, pulses;
	logic [9:0]  idx [6] = '{pin_mux_pkg::IDX_DIRECTION, pin_mux_pkg::IDX_FSEL0,
		pin_mux_pkg::IDX_ROUTE, pin_mux_pkg::IDX_LEVEL, pin_mux_pkg::IDX_INVERT,
		pin_mux_pkg::IDX_PHASE};
	logic [7:0]  msk [6] = '{8'h07, 8'h0f, 8'hff, 8'h07, 8'h07, 8'h0f};
	row_s        rows [8] = '{'{4'h0, 3'h0, 3'h3, 5'h1f, 3'h6}, '{4'h8, 3'h0, 3'h0, 5'h01, 3'h1},
		'{4'h9, 3'h0, 3'h2, 5'h1d, 3'h4}, '{4'hb, 3'h0, 3'h1, 5'h04, 3'h3},
		'{4'hc, 3'h4, 3'h0, 5'h17, 3'h1}, '{4'hd, 3'h7, 3'h0, 5'h10, 3'h6},
		'{4'h5, 3'h3, 3'h7, 5'h1f, 3'h0}, '{4'hf, 3'h0, 3'h4, 5'h1f, 3'h0}};

	pin_function_mux_sync i_pin_function_mux_sync
	(
		.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.warning_out_n(src[0]), .serial_audio_data_out(src[1]), .fault_out_n(src[2]),
		.supply_drop_flag(src[3]), .class_h_control(src[4]), .internal_sync(isync),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .drivers_hiz(hiz),
		.switching_stop(stop), .pin_reset_req(rreq), .spi_data_in(spi),
		.ramp_sync_pulse(spulse), .ramp_phase_sel(ph_sel), .ramp_phase_deg(ph_deg)
	);
	pin_far_side i_pin_far_side
	(
		.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
	);

	initial
	begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk)
		if (spulse === 1'h1)
			pulses++;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	task automatic stop_test;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask

	// Request is held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
	begin
		k = 0;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'h1;
		// Sample pready at the rising edge itself; the request stands until then
		do
		begin
			@(posedge mclk);
			k++;
		end
		while (pready !== 1'h1 && k < 20);
		if (k >= 20)
			miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	end
	endtask

	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		apb(1'h1, {i, 2'h0}, d);
	endtask

	task automatic rg(input logic [9:0] i, input logic [7:0] e);
	begin
		apb(1'h0, {i, 2'h0}, 8'h00);
		chk(rd, {24'h0, e});
	end
	endtask

	task automatic wait_n(input int n);
	begin
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	end
	endtask

	task automatic sync_try(input logic [7:0] ph, input logic on_pin, input int n);
	begin
		wr(idx[2], 8'h10);
		wr(idx[5], ph);
		ext_en <= 3'h7;
		ext_val <= 3'h0;
		isync <= 1'h0;
		wait_n(6);
		pulses = 0;
		@(posedge mclk);
		if (on_pin)
			ext_val <= 3'h2;
		else
			isync <= 1'h1;
		wait_n(8);
		chk(pulses, n);
	end
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		stop_test;
	end

	initial
	begin
		logic [2:0] hot;
		logic       nz;
		reset = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		src = 5'h00;
		isync = 1'h0;
		ext_en = 3'h0;
		ext_val = 3'h0;
		miscompares = 0;
		n_tests = 0;
		pulses = 0;
		repeat (12) @(posedge mclk);
		reset <= 1'h0;
		wait_n(1);
		chk({pin_out, pin_oe}, 32'h0);
		for (int i = 0; i < 6; i++)
			rg(idx[i], 8'h00);
		foreach (rows[r])
		begin
			src <= rows[r].src;
			wr(idx[1], {4'h0, rows[r].fs});
			wr(idx[4], {5'h0, rows[r].inv});
			wr(idx[3], {5'h0, rows[r].lvl});
			wait_n(2);
			chk({29'h0, pin_out}, {29'h0, rows[r].pins});
		end
		// Reserved bits are not stored and read back as zero
		for (int i = 0; i < 6; i++)
		begin
			wr(idx[i], 8'hff);
			rg(idx[i], msk[i]);
			wr(idx[i], 8'h00);
		end
		apb(1'h0, 12'h19c, 8'h00);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'h1, 12'h18d, 8'h07);
		chk({31'h0, err}, 32'h1);
		rg(idx[1], 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			wr(idx[0], 8'(1 << i));
			wait_n(1);
			chk({29'h0, pin_oe}, (32'h2 << i) % 32'h7);
		end
		wr(idx[0], 8'h00);
		for (int f = 0; f < 4; f++)
			for (int c = 0; c < 4; c++)
			begin
				if (f == 2)
					continue;
				hot = (c != 0) ? 3'(1 << (c % 3)) : 3'h0;
				nz = (c != 0);
				ext_en <= 3'h7;
				ext_val <= (f == 3) ? hot : ~hot;
				wr(idx[2], 8'(c << (2 * f)));
				wait_n(4);
				chk({hiz, stop, rreq, spi}, (f == 0) ? {nz, nz, 2'h0} : (f == 1) ?
					{2'h0, 1'(c == 1 || c == 2), 1'h0} : {3'h0, nz});
			end
		for (int s = 0; s < 4; s++)
		begin
			wr(idx[5], 8'(s << 2));
			wait_n(1);
			chk({ph_deg, 6'h0, ph_sel}, {8'(s * 8'h2d), 6'h0, 2'(s)});
		end
		sync_try(8'h03, 1'h0, 1);
		sync_try(8'h02, 1'h0, 0);
		sync_try(8'h01, 1'h1, 1);
		sync_try(8'h01, 1'h0, 0);
		sync_try(8'h03, 1'h1, 0);
		wr(idx[3], 8'h07);
		reset <= 1'h1;
		repeat (2) @(posedge mclk);
		reset <= 1'h0;
		wait_n(1);
		chk({29'h0, pin_out}, 32'h0);
		rg(idx[3], 8'h00);
		stop_test;
	end
endmodule
